// file: scp_device.sv
/*
  Serial control port, device end: instruction decode, buffer and
  active register sets, update copy and readback drive.
  Assumes the master keeps the link framing: cs low before any shift
  clock edge, and the shift clock still while cs is high.
*/
// How it works
// (R1) Sample instruction and write bits on rise.
// (R2) Change readback bits on shift clock fall.
// (R3) Reset to three-wire; config bit 0 splits.
// (R4) Cs high releases both data pins.
// (R5) Master lowers cs before any clock.
// (R6) First sixteen rising edges carry the instruction.
// (R7) Instruction: direction, length, thirteen-bit address.
// (R8) Length codes one, two, three bytes, stream.
// (R9) Short transfers stall at byte edges, resume.
// (R10) Master aborts with one to seven clocks.
// (R11) Cs rising mid-byte resets, drops partial data.
// (R12) Streams run any length, end by cs; the device stops a stream after the byte at update_trigger.
// (R13) Address steps by bit order; stream stops.
// (R14) Unused addresses stepped through, writes harmless.
// (R15) Writes hit buffer; update bit copies, clears.
// (R16) Update applies all buffered changes at once.
// (R17) Reads shift out N bytes or stream.
// (R18) Readback select picks buffer or active set.
// (R19) Only long instruction mode, default setting.
// (R20) Register space spans port_config to update_trigger.
// (R21) Port keeps working during pin power-down.
// (R22) Config writes mirror nibbles; MSB-first default.
// (R23) Completed cycle clears bit and byte counters.
// (R24) Unused addresses read back as zero.
`timescale 1ns/1ns
`include "scp_map.svh"

module scp_device import scp_pkg::*; (
  input wire logic srst_i,
  scp_if.dev link,
  input wire logic [9:0] act_addr_i,
  output logic [7:0] act_data_o,
  output logic update_tog_o
);
  scp_rise_t r;
  scp_rise_t next_r;
  scp_fall_t f;
  scp_fall_t next_f;
  logic [7:0] buf_mem [0:`SCP_NREGS-1];
  logic [7:0] act_mem [0:`SCP_NREGS-1];
  logic abort_tog;
  logic mem_we;
  logic mem_copy;
  logic [9:0] mem_addr;
  logic [7:0] mem_wdata;

  // Readback mux; addresses past the map read as zero
  function automatic logic [7:0] rd_byte(logic [12:0] a, logic act,
                                         logic [7:0] cfg);
    logic [7:0] v;
    v = 8'h00;
    if (a == `SCP_ADDR_CFG) begin
      v = cfg;
    end else if (a <= `SCP_ADDR_LAST) begin // see (R20)
      v = act ? act_mem[a[9:0]] : buf_mem[a[9:0]]; // see (R18)
    end
    rd_byte = v; // see (R24)
  endfunction : rd_byte

  // Next address: down in MSB-first, up in LSB-first, 0 wraps to top
  function automatic logic [12:0] step_addr(logic [12:0] a, logic lsb);
    logic [12:0] n;
    if (lsb) begin
      n = 13'(a + 13'h0001);
    end else if (a == `SCP_ADDR_CFG) begin
      n = `SCP_ADDR_LAST;
    end else begin
      n = 13'(a - 13'h0001);
    end
    step_addr = n; // see (R13)
  endfunction : step_addr

  // A stream end or a mid-byte cs rise must restart the port; a stall
  // at a byte edge of a short transfer must not. The rise-domain state
  // is stable here because the shift clock is still around cs edges.
  always_ff @(posedge link.cs_n or posedge srst_i) begin
    if (srst_i) begin
      abort_tog <= 1'b0;
    end else if (r.bits[2:0] != 3'h0 || r.phase == SCP_DONE || // see (R9)
                 (r.phase == SCP_DATA && r.len == `SCP_LEN_STREAM)) begin
      abort_tog <= ~abort_tog; // see (R11)
    end
  end

  // Rising-edge shifter and decoder; no sleep gating anywhere
  always_comb begin
    scp_rise_t s;
    logic [15:0] w;
    logic [7:0] b;
    logic lsb;
    logic done;
    s = r;
    w = 16'h0000;
    b = 8'h00;
    lsb = 1'b0;
    done = 1'b0;
    mem_we = 1'b0;
    mem_copy = 1'b0;
    mem_addr = 10'h000;
    mem_wdata = 8'h00;
    // Port stays live whatever the sleep pin does, see (R21)
    if (abort_tog != r.seen) begin
      s.seen = abort_tog;
      s.phase = SCP_INSTR; // see (R11)
      s.bits = 4'h0;
    end
    next_r = s;
    next_r.act_q = act_mem[act_addr_i];
    lsb = s.cfg[`SCP_CFG_LSB_BIT];
    w = scp_shift_in(s.sh, link.sdio_in, lsb); // see (R1)
    b = lsb ? w[15:8] : w[7:0];
    next_r.sh = w;
    case (s.phase)
      SCP_INSTR: begin
        next_r.bits = 4'(s.bits + 4'h1);
        if (s.bits == `SCP_INSTR_TOP) begin // see (R6)
          next_r.rw = w[15]; // see (R7)
          next_r.len = w[14:13];
          next_r.addr = w[12:0];
          next_r.left = w[14:13]; // see (R8)
          next_r.phase = SCP_DATA;
          next_r.bits = 4'h0;
          next_r.out_byte = rd_byte(w[12:0],
                            buf_mem[4][`SCP_RBSEL_ACT_BIT], s.cfg);
        end
      end
      SCP_DATA: begin
        next_r.bits = 4'(s.bits + 4'h1);
        if (s.bits == `SCP_BYTE_TOP) begin
          if (!s.rw && s.addr <= `SCP_ADDR_LAST) begin
            mem_we = 1'b1; // see (R15)
            mem_addr = s.addr[9:0];
            mem_wdata = b;
            if (s.addr == `SCP_ADDR_UPD) begin
              mem_copy = b[`SCP_UPD_BIT]; // see (R16)
              mem_wdata[`SCP_UPD_BIT] = 1'b0; // see (R15)
            end
            if (s.addr == `SCP_ADDR_CFG) begin
              next_r.cfg = b; // see (R22)
            end
          end
          // Writes past the map are taken and dropped, see (R14)
          next_r.addr = step_addr(s.addr, lsb);
          next_r.bits = 4'h0;
          if (s.len == `SCP_LEN_STREAM) begin
            done = (s.addr == `SCP_ADDR_LAST); // see (R13)
          end else begin
            done = (s.left == 2'h0); // see (R17)
            next_r.left = 2'(s.left - 2'h1);
          end
          if (done && s.len == `SCP_LEN_STREAM) begin
            next_r.phase = SCP_DONE;
          end else if (done) begin
            next_r.phase = SCP_INSTR; // see (R23)
          end else begin
            next_r.out_byte = rd_byte(step_addr(s.addr, lsb),
                              buf_mem[4][`SCP_RBSEL_ACT_BIT],
                              mem_we && s.addr == `SCP_ADDR_CFG ?
                              b : s.cfg); // see (R12)
          end
        end
      end
      SCP_DONE: begin
        next_r.bits = 4'(s.bits + 4'h1);
      end
      default: begin
        next_r.phase = SCP_INSTR;
      end
    endcase
    if (mem_copy) begin
      next_r.upd_tog = ~s.upd_tog;
    end
  end

  always_ff @(posedge link.sclk) begin
    if (srst_i) begin
      r <= '0;
      r.phase <= SCP_INSTR;
      r.cfg <= `SCP_CFG_RESET; // see (R3) (R19)
      r.seen <= abort_tog;
    end else begin
      r <= next_r;
    end
  end

  // Buffer and active sets; an update copies every byte on one edge
  always_ff @(posedge link.sclk) begin
    if (srst_i) begin
      for (int i = 0; i < `SCP_NREGS; i++) begin
        buf_mem[i] <= (i == 0) ? `SCP_CFG_RESET : `SCP_REG_RESET;
        act_mem[i] <= (i == 0) ? `SCP_CFG_RESET : `SCP_REG_RESET;
      end
    end else begin
      if (mem_we) begin
        buf_mem[mem_addr] <= mem_wdata; // see (R15)
      end
      if (mem_copy) begin
        for (int i = 0; i < `SCP_NREGS; i++) begin
          act_mem[i] <= (mem_we && 10'(i) == mem_addr) ?
                        mem_wdata : buf_mem[i]; // see (R16)
        end
      end
    end
  end

  // Falling-edge drive; which pin depends on the three/four-wire bit
  always_comb begin
    logic rd_on;
    rd_on = (r.phase == SCP_DATA) && r.rw;
    next_f.sd = scp_bit_at({8'h00, r.out_byte}, {1'b0, r.bits[2:0]},
                r.cfg[`SCP_CFG_LSB_BIT], `SCP_BYTE_TOP); // see (R2)
    next_f.oe_sd = rd_on && !r.cfg[`SCP_CFG_UNI_BIT]; // see (R3)
    next_f.oe_rb = rd_on && r.cfg[`SCP_CFG_UNI_BIT];
  end

  // Cs high clears the enables at once, even with no clock running
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      f <= '0; // see (R4)
    end else begin
      f <= next_f;
    end
  end

  assign link.dev_sdio_o = f.sd;
  assign link.dev_sdio_oe = f.oe_sd;
  assign link.dev_rb_o = f.sd;
  assign link.dev_rb_oe = f.oe_rb;
  assign act_data_o = r.act_q;
  assign update_tog_o = r.upd_tog;
endmodule : scp_device

// file: scp_map.svh
/*
  Constants of the serial control port: register offsets, field
  positions, reset values and link timing counts.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// Register offsets (byte addresses on the link)
`define SCP_ADDR_CFG 13'h0000
`define SCP_ADDR_RBSEL 13'h0004
`define SCP_ADDR_UPD 13'h0232
`define SCP_ADDR_LAST 13'h0232
`define SCP_NREGS 563

// Field positions
`define SCP_CFG_UNI_BIT 0
`define SCP_CFG_LSB_BIT 1
`define SCP_RBSEL_ACT_BIT 0
`define SCP_UPD_BIT 0

// Reset values
`define SCP_CFG_RESET 8'h18
`define SCP_REG_RESET 8'h00

// Instruction layout and length codes
`define SCP_INSTR_TOP 4'hf
`define SCP_BYTE_TOP 4'h7
`define SCP_LEN_STREAM 2'h3

// Host clock divider: system clocks per half shift-clock period
`define SCP_HOST_HALF 8

`endif

// file: scp_pkg.sv
/*
  Types shared by both ends of the serial control port, plus the small
  bit helpers that both ends need.
  Assumes scp_map.svh is on the include path.
*/
`include "scp_map.svh"

package scp_pkg;

  typedef enum logic [1:0] {SCP_INSTR, SCP_DATA, SCP_DONE} scp_phase_t;

  typedef struct packed {
    scp_phase_t phase;
    logic [3:0] bits;
    logic [15:0] sh;
    logic rw;
    logic [1:0] len;
    logic [12:0] addr;
    logic [1:0] left;
    logic [7:0] cfg;
    logic [7:0] out_byte;
    logic seen;
    logic [7:0] act_q;
    logic upd_tog;
  } scp_rise_t;

  typedef struct packed {
    logic sd;
    logic oe_sd;
    logic oe_rb;
  } scp_fall_t;

  typedef enum logic [2:0] {
    SCP_H_IDLE, SCP_H_LOW, SCP_H_HIGH, SCP_H_WAIT, SCP_H_STALL, SCP_H_END
  } scp_hstate_t;

  typedef struct packed {
    scp_hstate_t st;
    logic [7:0] cnt;
    logic cs_n;
    logic sclk;
    logic readback_out_pin;
    logic oe;
    logic instr;
    logic [3:0] idx;
    logic [15:0] sh;
    logic [7:0] rdsh;
    logic rw;
    logic lsb;
    logic uni;
    logic stream;
    logic [7:0] left;
    logic cmd_ready;
    logic wr_ready;
    logic rd_valid;
    logic [7:0] rd_data;
  } scp_host_t;

  // Shift one bit into a 16-bit register in the active bit order
  function automatic logic [15:0] scp_shift_in(logic [15:0] sh, logic b,
                                               logic lsb);
    scp_shift_in = lsb ? {b, sh[15:1]} : {sh[14:0], b};
  endfunction : scp_shift_in

  // Bit number idx of a word whose top bit is top, in the active order
  function automatic logic scp_bit_at(logic [15:0] sh, logic [3:0] idx,
                                      logic lsb, logic [3:0] top);
    logic [3:0] pos;
    pos = lsb ? idx : 4'(top - idx);
    scp_bit_at = sh[pos];
  endfunction : scp_bit_at

endpackage : scp_pkg

// file: scp_if.sv
/*
  Link between the serial master and the serial control port.
  Assumes nothing outside; it resolves the shared data pin from the
  two output enables and lets an undriven pin read as low.
*/
`timescale 1ns/1ns

interface scp_if;
  logic cs_n;
  logic sclk;
  logic host_sdio_o;
  logic host_sdio_oe;
  logic dev_sdio_o;
  logic dev_sdio_oe;
  logic dev_rb_o;
  logic dev_rb_oe;
  logic sdio_in;
  logic rb_in;

  // Wire levels worked out from the enables
  assign sdio_in = host_sdio_oe ? host_sdio_o :
                   (dev_sdio_oe ? dev_sdio_o : 1'b0);
  assign rb_in = dev_rb_oe ? dev_rb_o : 1'b0;

  modport dev (
    input cs_n, sclk, sdio_in,
    output dev_sdio_o, dev_sdio_oe, dev_rb_o, dev_rb_oe
  );

  modport host (
    output cs_n, sclk, host_sdio_o, host_sdio_oe,
    input sdio_in, rb_in
  );
endinterface : scp_if

// file: scp_sync.sv
/*
  Pin input synchroniser: four flops, and a change is passed on only
  once the second and third flops agree.
  Assumes d_i is asynchronous to clk_i.
*/
`timescale 1ns/1ns

module scp_sync (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic d_i,
  output logic q_o
);
  logic [3:0] r;
  logic [3:0] next_r;

  // Stage 0 feeds only stage 1; the filter looks at stages 1 and 2
  always_comb begin
    next_r[0] = d_i;
    next_r[1] = r[0];
    next_r[2] = r[1];
    next_r[3] = (r[1] == r[2]) ? r[2] : r[3];
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= 4'h0;
    end else begin
      r <= next_r;
    end
  end

  assign q_o = r[3];
endmodule : scp_sync

// file: scp_host.sv
/*
  Serial master end: turns user commands into framed link cycles,
  making the shift clock from clk_i by a divider.
  Assumes the device end sits on the same scp_if; HALF must leave room
  for the readback path (device flop plus four sync flops), so >= 6.
*/
`timescale 1ns/1ns
`include "scp_map.svh"

module scp_host import scp_pkg::*; #(
  parameter int HALF = `SCP_HOST_HALF
) (
  input wire logic clk_i,
  input wire logic srst_i,
  scp_if.host link,
  input wire logic uni_i,
  input wire logic lsb_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_rw_i,
  input wire logic [1:0] cmd_len_i,
  input wire logic [12:0] cmd_addr_i,
  input wire logic [7:0] cmd_count_i,
  output logic cmd_ready_o,
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_ready_o,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o
);
  localparam logic [7:0] HALF_END = 8'(HALF - 1);

  scp_host_t r;
  scp_host_t next_r;
  logic din_raw;
  logic din;

  // Readback pin chosen by the mode the master set in the device
  assign din_raw = r.uni ? link.rb_in : link.sdio_in;

  scp_sync u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i(din_raw),
    .q_o(din)
  );

  // Master sequencing: cs low first, then 16 instruction bits, then data
  always_comb begin
    logic last;
    logic [7:0] rem;
    last = 1'b0;
    rem = 8'h00;
    next_r = r;
    next_r.wr_ready = 1'b0;
    next_r.rd_valid = 1'b0;
    next_r.cnt = 8'(r.cnt + 8'h01);
    case (r.st)
      SCP_H_IDLE: begin
        next_r.cs_n = 1'b1;
        next_r.sclk = 1'b0;
        next_r.oe = 1'b0;
        next_r.cmd_ready = 1'b1;
        if (cmd_valid_i && r.cmd_ready) begin
          next_r.cmd_ready = 1'b0;
          next_r.rw = cmd_rw_i;
          next_r.lsb = lsb_i;
          next_r.uni = uni_i;
          next_r.stream = (cmd_len_i == `SCP_LEN_STREAM);
          next_r.sh = {cmd_rw_i, cmd_len_i, cmd_addr_i}; // see (R7)
          next_r.left = (cmd_len_i == `SCP_LEN_STREAM) ? cmd_count_i :
                        8'({6'h00, cmd_len_i} + 8'h01); // see (R8)
          next_r.instr = 1'b1;
          next_r.idx = 4'h0;
          next_r.cs_n = 1'b0; // see (R5)
          next_r.oe = 1'b1;
          next_r.readback_out_pin = scp_bit_at({cmd_rw_i, cmd_len_i, cmd_addr_i},
                                  4'h0, lsb_i, `SCP_INSTR_TOP);
          next_r.cnt = 8'h00;
          next_r.st = SCP_H_LOW;
        end
      end
      SCP_H_LOW: begin
        if (r.cnt == HALF_END) begin
          next_r.cnt = 8'h00;
          next_r.sclk = 1'b1;
          next_r.st = SCP_H_HIGH;
          if (!r.instr && r.rw) begin
            next_r.rdsh = r.lsb ? {din, r.rdsh[7:1]} : {r.rdsh[6:0], din};
          end
        end
      end
      SCP_H_HIGH: begin
        if (r.cnt == HALF_END) begin
          next_r.cnt = 8'h00;
          next_r.sclk = 1'b0;
          last = r.instr ? (r.idx == `SCP_INSTR_TOP) :
                 (r.idx == `SCP_BYTE_TOP); // see (R6)
          if (!last) begin
            next_r.idx = 4'(r.idx + 4'h1);
            next_r.readback_out_pin = scp_bit_at(r.sh, 4'(r.idx + 4'h1), r.lsb,
                         r.instr ? `SCP_INSTR_TOP : `SCP_BYTE_TOP);
            next_r.st = SCP_H_LOW;
          end else begin
            if (!r.instr && r.rw) begin
              next_r.rd_data = r.rdsh;
              next_r.rd_valid = 1'b1;
            end
            rem = r.instr ? r.left : 8'(r.left - 8'h01);
            next_r.left = rem;
            next_r.instr = 1'b0;
            next_r.idx = 4'h0;
            next_r.oe = 1'b0;
            if (rem == 8'h00) begin
              next_r.st = SCP_H_END; // see (R12)
            end else if (r.rw) begin
              next_r.st = SCP_H_LOW; // see (R17)
            end else if (wr_valid_i) begin
              next_r.sh = {8'h00, wr_data_i};
              next_r.wr_ready = 1'b1;
              next_r.oe = 1'b1;
              next_r.readback_out_pin = scp_bit_at({8'h00, wr_data_i}, 4'h0, r.lsb,
                                      `SCP_BYTE_TOP);
              next_r.st = SCP_H_LOW;
            end else begin
              // Short transfers may stall with cs high at a byte edge;
              // a stream keeps cs low, as a cs rise would end it
              next_r.st = r.stream ? SCP_H_WAIT : SCP_H_STALL; // see (R9)
            end
          end
        end
      end
      SCP_H_WAIT, SCP_H_STALL: begin
        next_r.cs_n = (r.st == SCP_H_STALL);
        if (wr_valid_i) begin
          next_r.cs_n = 1'b0;
          next_r.sh = {8'h00, wr_data_i};
          next_r.wr_ready = 1'b1;
          next_r.oe = 1'b1;
          next_r.readback_out_pin = scp_bit_at({8'h00, wr_data_i}, 4'h0, r.lsb,
                                  `SCP_BYTE_TOP);
          next_r.cnt = 8'h00;
          next_r.st = SCP_H_LOW;
        end
      end
      SCP_H_END: begin
        next_r.oe = 1'b0;
        if (r.cnt == HALF_END) begin
          next_r.cs_n = 1'b1; // see (R12)
          next_r.cnt = 8'h00;
          next_r.st = SCP_H_IDLE;
        end
      end
      default: begin
        next_r.st = SCP_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      // One assignment, so cs never glitches low while in reset
      r <= '{st: SCP_H_IDLE, cs_n: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign link.cs_n = r.cs_n;
  assign link.sclk = r.sclk;
  assign link.host_sdio_o = r.readback_out_pin;
  assign link.host_sdio_oe = r.oe;
  assign cmd_ready_o = r.cmd_ready;
  assign wr_ready_o = r.wr_ready;
  assign rd_valid_o = r.rd_valid;
  assign rd_data_o = r.rd_data;
endmodule : scp_host

// file: scp_link_monitor.sv
/*
  Link checker for the serial control port.
  Assumes it sits beside the scp_if that joins the two ends.
*/
`timescale 1ns/1ns

module scp_link_monitor (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic host_sdio_o,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_o,
  input wire logic dev_sdio_oe,
  input wire logic dev_rb_o,
  input wire logic dev_rb_oe
);
  logic [2:0] bits;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  // Shift edges in a frame, modulo one byte; cleared while deselected
  always_ff @(posedge clk_i) begin
    if (srst_i || cs_n) begin
      bits <= 3'h0;
    end else if ($rose(sclk)) begin
      bits <= bits + 3'h1;
    end
  end

  // High half of the shift clock lasts eight system clocks
  sequence s_high;
    sclk [*8] ##1 !sclk;
  endsequence

  chk_cs_release: assert property (
    cs_n |-> !dev_sdio_oe && !dev_rb_oe)
    else $error("device drives a pin while deselected");
  chk_no_contend: assert property (!(host_sdio_oe && dev_sdio_oe))
    else $error("both ends drive the shared pin");
  chk_one_pin: assert property (!(dev_sdio_oe && dev_rb_oe))
    else $error("device drives both data pins");
  chk_clk_still: assert property (cs_n |-> !sclk)
    else $error("shift clock high outside a frame");
  chk_sclk_half: assert property ($rose(sclk) |-> s_high)
    else $error("shift clock high half has the wrong length");
  chk_byte_edge: assert property ($rose(cs_n) |-> bits == 3'h0)
    else $error("frame ended off a byte boundary");
  chk_host_hold: assert property (host_sdio_oe && sclk |->
    $stable(host_sdio_o))
    else $error("master data moved while shift clock high");
  chk_sdio_fall: assert property (
    dev_sdio_oe && $changed(dev_sdio_o) |-> $fell(sclk))
    else $error("shared pin readback moved off a falling edge");
  chk_rb_fall: assert property (
    dev_rb_oe && $changed(dev_rb_o) |-> $fell(sclk))
    else $error("readback pin moved off a falling edge");
endmodule : scp_link_monitor

// file: serial_control_port_regs_tb.sv
/*
  Bench for the serial control port: master and device joined by
  scp_if, driven through the master's user side.
  Assumes scp_pkg, scp_if and both ends are compiled first.
*/
`timescale 1ns/1ns
`include "scp_map.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end

module serial_control_port_regs_tb;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic dev_srst = 1'b1;
  logic uni = 1'b0;
  logic lsb = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_rw = 1'b0;
  logic [1:0] cmd_len = 2'h0;
  logic [12:0] cmd_addr = 13'h0;
  logic [7:0] cmd_count = 8'h0;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h0;
  logic [9:0] act_addr = 10'h0;
  logic cmd_ready, wr_ready, rd_valid, upd_tog, tog0;
  logic [7:0] rd_data, act_data;
  logic [12:0] a0;
  logic [7:0] wq[$];
  logic [7:0] rdq[$];
  logic [7:0] bufm [0:1023];
  logic [7:0] actm [0:1023];
  int num_errors = 0;
  int n_tests = 0;
  int seed = 32'h2cd2ad88;
  int l;

  scp_if link ();
  scp_host i_scp_host (.clk_i(clk_i), .srst_i(srst_i), .link(link),
    .uni_i(uni), .lsb_i(lsb), .cmd_valid_i(cmd_valid), .cmd_rw_i(cmd_rw),
    .cmd_len_i(cmd_len), .cmd_addr_i(cmd_addr), .cmd_count_i(cmd_count),
    .cmd_ready_o(cmd_ready), .wr_valid_i(wr_valid), .wr_data_i(wr_data),
    .wr_ready_o(wr_ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
  scp_device i_scp_device (.srst_i(dev_srst), .link(link),
    .act_addr_i(act_addr), .act_data_o(act_data), .update_tog_o(upd_tog));
  scp_link_monitor i_scp_link_monitor (.clk_i(clk_i), .srst_i(srst_i),
    .cs_n(link.cs_n), .sclk(link.sclk), .host_sdio_o(link.host_sdio_o),
    .host_sdio_oe(link.host_sdio_oe), .dev_sdio_o(link.dev_sdio_o),
    .dev_sdio_oe(link.dev_sdio_oe), .dev_rb_o(link.dev_rb_o),
    .dev_rb_oe(link.dev_rb_oe));

  // System clock, 100 MHz
  always #5 clk_i = ~clk_i;

  // Next byte address; MSB-first wraps from zero to the update address
  function automatic logic [12:0] step(logic [12:0] a);
    step = lsb ? a + 13'h1 : (a == 13'h0 ? `SCP_ADDR_LAST : a - 13'h1);
  endfunction : step

  // Expected readback of one address
  function automatic logic [7:0] rd_model(logic [12:0] a);
    if (a > `SCP_ADDR_LAST) rd_model = 8'h00;
    else if (a == 13'h0 || !bufm[4][0]) rd_model = bufm[a[9:0]];
    else rd_model = actm[a[9:0]];
  endfunction : rd_model

  task final_report;
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // One link cycle; a stall makes the master drop cs after byte one
  task automatic xfer(input logic rw, input logic [1:0] len,
                      input logic [12:0] addr, input int n, input int stall);
    int i;
    int k;
    i = 0;
    k = 0;
    rdq = {};
    while (cmd_ready !== 1'b1 && k < 100) begin
      @(negedge clk_i);
      k++;
    end
    if (cmd_ready !== 1'b1) begin
      num_errors++;
      final_report();
    end
    cmd_valid = 1'b1;
    cmd_rw = rw;
    cmd_len = len;
    cmd_addr = addr;
    cmd_count = 8'(n);
    wr_valid = !rw;
    if (!rw) wr_data = wq[0];
    @(negedge clk_i);
    cmd_valid = 1'b0;
    for (k = 0; k < 20000; k++) begin
      @(negedge clk_i);
      if (rd_valid === 1'b1) rdq.push_back(rd_data);
      if (wr_ready === 1'b1) begin
        i++;
        if (i >= wq.size() || stall > 0) wr_valid = 1'b0;
        repeat (stall) @(negedge clk_i);
        stall = 0;
        if (i < wq.size()) begin
          wr_data = wq[i];
          wr_valid = 1'b1;
        end
      end
      if (cmd_ready === 1'b1) break;
    end
    if (k >= 20000 || cmd_ready !== 1'b1) begin
      num_errors++;
      final_report();
    end
  endtask : xfer

  // Write n bytes, first one d, and track the buffer and active sets
  task automatic wr(input logic [1:0] len, input logic [12:0] addr,
                    input int n, input logic [7:0] d, input int stall);
    logic [12:0] a;
    a = addr;
    wq = {d};
    repeat (n - 1) wq.push_back(8'($random(seed)));
    foreach (wq[j]) begin
      if (a == `SCP_ADDR_UPD && wq[j][0]) begin
        bufm[a[9:0]] = wq[j] & 8'hfe;
        actm = bufm;
      end else if (a <= `SCP_ADDR_LAST) bufm[a[9:0]] = wq[j];
      a = step(a);
    end
    xfer(1'b0, len, addr, n, stall);
  endtask : wr

  task automatic rd(input logic [1:0] len, input logic [12:0] addr,
                    input int n);
    logic [12:0] a;
    a = addr;
    wq = {};
    xfer(1'b1, len, addr, n, 0);
    `CHK(32'(rdq.size()), 32'(n))
    foreach (rdq[j]) begin
      `CHK(rdq[j], rd_model(a))
      a = step(a);
    end
  endtask : rd

  initial begin
    foreach (bufm[j]) bufm[j] = 8'h00;
    bufm[0] = `SCP_CFG_RESET;
    actm = bufm;
    repeat (3) @(negedge clk_i);
    srst_i = 1'b0;
    // The device resets on shift edges, so one frame clocks it through
    wr(2'h0, 13'h10, 1, 8'h00, 0);
    dev_srst = 1'b0;
    rd(2'h0, 13'h0, 1);
    rd(2'h0, 13'h4, 1);
    // Random short writes, some stalled, read back from the buffer
    repeat (6) begin
      a0 = 13'h40 + 13'($random(seed) & 32'h1bf);
      l = ($random(seed) & 32'h7fff) % 3;
      // A stall longer than one byte time, so cs really rises
      wr(2'(l), a0, l + 1, 8'($random(seed)), l * 150);
      rd(2'(l), a0, l + 1);
    end
    // Active set changes only on the update bit
    act_addr = a0[9:0];
    rd(2'h0, a0, 1);
    `CHK(act_data, 8'h00)
    tog0 = upd_tog;
    wr(2'h0, `SCP_ADDR_UPD, 1, 8'h01, 0);
    rd(2'h0, `SCP_ADDR_UPD, 1);
    `CHK(act_data, actm[a0[9:0]])
    `CHK(upd_tog, ~tog0)
    wr(2'h0, 13'h4, 1, 8'h01, 0);
    wr(2'h0, a0, 1, 8'h5a, 0);
    rd(2'h0, a0, 1);
    wr(2'h0, 13'h4, 1, 8'h00, 0);
    // Streams, unused space and the wrap onto the update address
    wr(2'h3, 13'h1a0, 5, 8'h3c, 0);
    rd(2'h3, 13'h1a0, 5);
    wr(2'h0, 13'h300, 1, 8'ha5, 0);
    rd(2'h0, 13'h300, 1);
    rd(2'h3, 13'h1, 3);
    // Readback on its own pin, then LSB-first order
    wr(2'h0, 13'h0, 1, 8'h99, 0);
    uni = 1'b1;
    rd(2'h0, 13'h0, 1);
    wr(2'h0, 13'h0, 1, 8'hdb, 0);
    lsb = 1'b1;
    wr(2'h1, 13'h120, 2, 8'h77, 0);
    rd(2'h1, 13'h120, 2);
    rd(2'h3, 13'h230, 3);
    final_report();
  end
endmodule : serial_control_port_regs_tb
